// ===== common/panel_if.sv
// Press events passed from the button synchroniser to the panel control.
// Each signal is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
interface panel_if;
	logic sensitivity_step_buttons_up;
	logic sensitivity_step_buttons_down;
	logic frequency_select_button_sel;
	logic mode_sel;

	modport src
	(
		output sensitivity_step_buttons_up,
		output sensitivity_step_buttons_down,
		output frequency_select_button_sel,
		output mode_sel
	);
	modport dst
	(
		input sensitivity_step_buttons_up,
		input sensitivity_step_buttons_down,
		input frequency_select_button_sel,
		input mode_sel
	);
endinterface

// ===== common/panel_pkg.sv
// Constants, display characters and helper functions for the front panel control.
// Assumes a 50 MHz system clock and the panel logic in rtl/.
package panel_pkg;

	// ************************************************************
	// Sizes and reset values
	// ************************************************************
	localparam int          CHANNELS        = 4;
	localparam int          CH_W            = 2;
	localparam logic [3:0]  SENSITIVITY_STEP_BUTTONS_MIN        = 4'h1;
	localparam logic [3:0]  SENSITIVITY_STEP_BUTTONS_MAX        = 4'h9;
	localparam logic [3:0]  SENSITIVITY_STEP_BUTTONS_DEFAULT    = 4'h6;
	localparam logic [1:0]  FREQUENCY_SELECT_BUTTON_LVL_DEFAULT = 2'h0;
	localparam logic [1:0]  MODE_DEFAULT    = 2'h0;
	localparam int          DELTA_W         = 16;
	localparam int          FREQUENCY_SELECT_BUTTON_W          = 8;
	localparam int          THR_W           = 9;
	localparam int          TIMER_W         = 28;
	localparam logic [2:0]  SEQ_LAST        = 3'h5;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ            = 50_000_000;
	localparam int SENSITIVITY_STEP_BUTTONS_SHOW_S       = 3;
	localparam int CHAR_SHOW_MS      = 750;
	localparam int SENSITIVITY_STEP_BUTTONS_SHOW_CYCLES  = SENSITIVITY_STEP_BUTTONS_SHOW_S * CLK_HZ;
	localparam int CHAR_SHOW_CYCLES  = CHAR_SHOW_MS * (CLK_HZ / 1000);

	// ************************************************************
	// Display characters: 0..9 are digits
	// ************************************************************
	localparam logic [4:0] CHAR_DASH  = 5'h10;
	localparam logic [4:0] CHAR_BLANK = 5'h11;

	typedef enum logic [1:0] {DISP_STRENGTH, DISP_SENSITIVITY_STEP_BUTTONS, DISP_FREQUENCY_SELECT_BUTTON} disp_type;

	// Segments g..a, active high
	function automatic logic [6:0] seg_of(input logic [4:0] c);
		case (c)
			5'h00: seg_of = 7'h3f;
			5'h01: seg_of = 7'h06;
			5'h02: seg_of = 7'h5b;
			5'h03: seg_of = 7'h4f;
			5'h04: seg_of = 7'h66;
			5'h05: seg_of = 7'h6d;
			5'h06: seg_of = 7'h7d;
			5'h07: seg_of = 7'h07;
			5'h08: seg_of = 7'h7f;
			5'h09: seg_of = 7'h6f;
			5'h10: seg_of = 7'h40;
			default: seg_of = 7'h00;
		endcase
	endfunction

	// Threshold in 0.01 percent units, doubling per step down
	function automatic logic [8:0] threshold(input logic [3:0] lvl);
		threshold = 9'h001 << (4'h9 - lvl);
	endfunction

endpackage

// ===== rtl/loop_panel.sv
// Front panel control of a four-channel loop detector: settings, buttons, display.
// Assumes detect state, inductance change and loop frequency arrive on this clock.
`timescale 1ns/1ps

// Operation
// [RL1] Each channel keeps its own sensitivity, mode and frequency level, set from the buttons.
// [RL2] Sensitivity has nine levels 1 to 9, with 9 the most sensitive.
// [RL3] After reset every channel's sensitivity is 6.
// [RL4] A first sensitivity press shows the current level for 3 seconds without changing it.
// [RL5] A further press within those 3 seconds steps the level and shows it for 3 more seconds.
// [RL6] Level 9 detects a 0.01 percent change and the threshold doubles per step down to 2.56 percent.
// [RL7] While the channel detects, the display shows the call strength; a frequency press still switches to the frequency display.
// [RL8] With no vehicle the call strength shown is zero.
// [RL9] While a vehicle is detected each press steps the level by one and strength is recomputed at once; presses during the frequency display are ignored.
// [RL10] The frequency button chooses one of four frequency levels per channel.
// [RL11] A frequency press shows the frequency level and then the measured loop frequency.
// [RL12] The frequency is shown in kilohertz with a dash before and after the digits.
// [RL13] The sequence is level digit, dash, each kilohertz digit, closing dash, one at a time.
// [RL14] Stepping saturates at levels 9 and 1.
// [RL15] When the level display times out the display returns to call strength.
module loop_panel
#(
	parameter int unsigned SENSITIVITY_STEP_BUTTONS_SHOW_CYCLES = panel_pkg::SENSITIVITY_STEP_BUTTONS_SHOW_CYCLES,
	parameter int unsigned CHAR_SHOW_CYCLES = panel_pkg::CHAR_SHOW_CYCLES
)
(
	// Clock and reset
	input  wire logic                         i_clk,
	input  wire logic                         i_rst_b,
	// Front panel buttons, raw pins
	input  wire logic [1:0]                   i_sensitivity_step_buttons,
	input  wire logic                         i_frequency_select_button,
	input  wire logic                         i_mode_button,
	input  wire logic [panel_pkg::CH_W-1:0]   i_channel_select,
	// Measurement side: detect state of all four channels, selected channel values for the rest
	input  wire logic [3:0]                   i_vehicle_detect,
	input  wire logic [panel_pkg::DELTA_W-1:0] i_inductance_delta,
	input  wire logic [panel_pkg::FREQUENCY_SELECT_BUTTON_W-1:0] i_loop_frequency_select_button_khz,
	// Display and indicators
	output logic [6:0]                        o_segments,
	output logic [3:0]                        o_vehicle_detect_indicator,
	output logic [3:0]                        o_sensitivity_level,
	output logic [1:0]                        o_frequency_level,
	output logic [1:0]                        o_channel_mode,
	output logic [panel_pkg::THR_W-1:0]       o_detect_threshold,
	output logic [3:0]                        o_call_strength
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed
	{
		panel_pkg::disp_type                disp;
		logic [3:0][3:0]                    sensitivity_step_buttons;
		logic [3:0][1:0]                    flvl;
		logic [3:0][1:0]                    mode;
		logic [panel_pkg::TIMER_W-1:0]      timer;
		logic [2:0]                         seq;
		logic [6:0]                         seg;
		logic [3:0]                         vehicle_detect_indicator;
		logic [3:0]                         sensitivity_step_buttons_o;
		logic [1:0]                         flvl_o;
		logic [1:0]                         mode_o;
		logic [panel_pkg::THR_W-1:0]        thr_o;
		logic [3:0]                         str_o;
	} state_type;

	localparam state_type RESET_STATE = '{
		disp:   panel_pkg::DISP_STRENGTH,
		sensitivity_step_buttons:   {4{panel_pkg::SENSITIVITY_STEP_BUTTONS_DEFAULT}},
		flvl:   {4{panel_pkg::FREQUENCY_SELECT_BUTTON_LVL_DEFAULT}},
		mode:   {4{panel_pkg::MODE_DEFAULT}},
		timer:  '0,
		seq:    3'h0,
		seg:    7'h3f,
		vehicle_detect_indicator:    4'h0,
		sensitivity_step_buttons_o: panel_pkg::SENSITIVITY_STEP_BUTTONS_DEFAULT,
		flvl_o: panel_pkg::FREQUENCY_SELECT_BUTTON_LVL_DEFAULT,
		mode_o: panel_pkg::MODE_DEFAULT,
		thr_o:  9'h008,
		str_o:  4'h0
	};

	localparam logic [panel_pkg::TIMER_W-1:0] SENSITIVITY_STEP_BUTTONS_LOAD = panel_pkg::TIMER_W'(SENSITIVITY_STEP_BUTTONS_SHOW_CYCLES);
	localparam logic [panel_pkg::TIMER_W-1:0] CHAR_LOAD = panel_pkg::TIMER_W'(CHAR_SHOW_CYCLES);

	// ************************************************************
	// Helpers
	// ************************************************************
	// Doublings of the change above the threshold, plus one
	function automatic logic [3:0] call_strength(input logic vehicle_detect_indicator, input logic [15:0] delta,
		input logic [3:0] lvl);
		logic [16:0] thr;
		call_strength = 4'h0;
		thr = {8'h00, panel_pkg::threshold(lvl)};
		if (vehicle_detect_indicator)
		begin
			for (int k = 0; k < 9; k++)
			begin
				if ({1'b0, delta} >= (thr << k))
				begin
					call_strength = 4'(k + 1);
				end
			end
		end
	endfunction

	function automatic logic [3:0] step_level(input logic [3:0] lvl, input logic up, input logic dn);
		step_level = lvl;
		if (up && !dn && lvl != panel_pkg::SENSITIVITY_STEP_BUTTONS_MAX)
		begin
			step_level = lvl + 4'h1;
		end
		else if (dn && !up && lvl != panel_pkg::SENSITIVITY_STEP_BUTTONS_MIN)
		begin
			step_level = lvl - 4'h1;
		end
	endfunction

	function automatic logic [4:0] frequency_select_button_char(input logic [2:0] idx, input logic [1:0] lvl,
		input logic [7:0] f);
		case (idx)
			3'h0: frequency_select_button_char = {3'h0, lvl} + 5'h01;
			3'h2: frequency_select_button_char = 5'(f / 8'd100);
			3'h3: frequency_select_button_char = 5'((f / 8'd10) % 8'd10);
			3'h4: frequency_select_button_char = 5'(f % 8'd10);
			default: frequency_select_button_char = panel_pkg::CHAR_DASH;
		endcase
	endfunction

	// ************************************************************
	// Buttons
	// ************************************************************
	panel_if btn ();

	panel_button_sync u_sync
	(
		.i_clk     (i_clk),
		.i_rst_b   (i_rst_b),
		.i_buttons ({i_mode_button, i_frequency_select_button, i_sensitivity_step_buttons}),
		.evt       (btn.src)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	state_type q;
	state_type d;

	always_comb
	begin
		logic [1:0]  ch;
		logic        press;
		logic        expire;
		logic [4:0]  chr;
		logic [3:0]  str;
		logic [2:0]  nxt;
		ch     = i_channel_select;
		d      = q;
		press  = btn.sensitivity_step_buttons_up | btn.sensitivity_step_buttons_down;
		expire = (q.timer == 28'h0000001);
		chr    = panel_pkg::CHAR_BLANK;
		str    = 4'h0;
		nxt    = q.seq + 3'h1;
		if (q.timer != '0)
		begin
			d.timer = q.timer - 28'h0000001;
		end
		case (q.disp)
			panel_pkg::DISP_STRENGTH:
			begin
				if (press && i_vehicle_detect[ch])
				begin
					d.sensitivity_step_buttons[ch] = step_level(q.sensitivity_step_buttons[ch], btn.sensitivity_step_buttons_up, btn.sensitivity_step_buttons_down); // RL9 RL14
				end
				else if (press)
				begin
					d.disp  = panel_pkg::DISP_SENSITIVITY_STEP_BUTTONS; // RL4
					d.timer = SENSITIVITY_STEP_BUTTONS_LOAD;
				end
				else if (btn.frequency_select_button_sel)
				begin
					d.disp  = panel_pkg::DISP_FREQUENCY_SELECT_BUTTON; // RL11
					d.seq   = 3'h0;
					d.timer = CHAR_LOAD;
				end
			end
			panel_pkg::DISP_SENSITIVITY_STEP_BUTTONS:
			begin
				if (press)
				begin
					d.sensitivity_step_buttons[ch] = step_level(q.sensitivity_step_buttons[ch], btn.sensitivity_step_buttons_up, btn.sensitivity_step_buttons_down); // RL5 RL14
					d.timer    = SENSITIVITY_STEP_BUTTONS_LOAD;
				end
				else if (btn.frequency_select_button_sel)
				begin
					d.disp  = panel_pkg::DISP_FREQUENCY_SELECT_BUTTON;
					d.seq   = 3'h0;
					d.timer = CHAR_LOAD;
				end
				else if (expire)
				begin
					d.disp = panel_pkg::DISP_STRENGTH; // RL15
				end
			end
			default:
			begin
				if (btn.frequency_select_button_sel)
				begin
					d.flvl[ch] = q.flvl[ch] + 2'h1; // RL10
					d.seq      = 3'h0;
					d.timer    = CHAR_LOAD;
				end
				else if (expire && q.seq == panel_pkg::SEQ_LAST)
				begin
					d.disp = panel_pkg::DISP_STRENGTH;
				end
				else if (expire)
				begin
					// Leading zero digits are skipped
					if (nxt == 3'h2 && i_loop_frequency_select_button_khz < 8'd100)
					begin
						nxt = 3'h3;
					end
					if (nxt == 3'h3 && i_loop_frequency_select_button_khz < 8'd10)
					begin
						nxt = 3'h4;
					end
					d.seq   = nxt; // RL13
					d.timer = CHAR_LOAD;
				end
			end
		endcase
		if (btn.mode_sel)
		begin
			d.mode[ch] = q.mode[ch] + 2'h1; // RL1
		end
		// Strength from the new level so a step shows next cycle
		str = call_strength(i_vehicle_detect[ch], i_inductance_delta, d.sensitivity_step_buttons[ch]); // RL7 RL8 RL9
		case (d.disp)
			panel_pkg::DISP_STRENGTH: chr = {1'b0, str};
			panel_pkg::DISP_SENSITIVITY_STEP_BUTTONS:     chr = {1'b0, d.sensitivity_step_buttons[ch]}; // RL2
			default:                  chr = frequency_select_button_char(d.seq, d.flvl[ch], i_loop_frequency_select_button_khz); // RL12
		endcase
		d.seg    = panel_pkg::seg_of(chr);
		d.vehicle_detect_indicator    = i_vehicle_detect;
		d.sensitivity_step_buttons_o = d.sensitivity_step_buttons[ch];
		d.flvl_o = d.flvl[ch];
		d.mode_o = d.mode[ch];
		d.thr_o  = panel_pkg::threshold(d.sensitivity_step_buttons[ch]); // RL6
		d.str_o  = str;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			q <= RESET_STATE; // RL3
		end
		else
		begin
			q <= d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign o_segments                 = q.seg;
	assign o_vehicle_detect_indicator = q.vehicle_detect_indicator;
	assign o_sensitivity_level        = q.sensitivity_step_buttons_o;
	assign o_frequency_level          = q.flvl_o;
	assign o_channel_mode             = q.mode_o;
	assign o_detect_threshold         = q.thr_o;
	assign o_call_strength            = q.str_o;

endmodule

// ===== rtl/panel_button_sync.sv
// Three-stage synchroniser and press detector for the four panel buttons.
// Assumes buttons are active high and already debounced mechanically.
`timescale 1ns/1ps
module panel_button_sync
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	// Raw buttons: up, down, frequency, mode
	input  wire logic [3:0] i_buttons,
	// Press events
	panel_if.src            evt
);

	typedef struct packed
	{
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] stable;
		logic [3:0] press;
	} sync_type;

	sync_type q;
	sync_type d;

	always_comb
	begin
		d       = q;
		d.s1    = i_buttons;
		d.s2    = q.s1;
		d.s3    = q.s2;
		// Only agreed levels count, first stage never looked at
		for (int i = 0; i < 4; i++)
		begin
			if (q.s2[i] == q.s3[i])
			begin
				d.stable[i] = q.s3[i];
			end
		end
		d.press = d.stable & ~q.stable;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign evt.sensitivity_step_buttons_up   = q.press[0];
	assign evt.sensitivity_step_buttons_down = q.press[1];
	assign evt.frequency_select_button_sel  = q.press[2];
	assign evt.mode_sel  = q.press[3];

endmodule

// ===== verif/loop_panel_props.sv
// Port checks for the loop panel control.
// Assumes one clock and a panel channel select held steady between presses.
`timescale 1ns/1ps
module loop_panel_props
(
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_b,
	// Inputs watched
	input wire logic [1:0]  i_channel_select,
	input wire logic [3:0]  i_vehicle_detect,
	input wire logic [15:0] i_inductance_delta,
	// Outputs watched
	input wire logic [3:0]  o_vehicle_detect_indicator,
	input wire logic [3:0]  o_sensitivity_level,
	input wire logic [1:0]  o_frequency_level,
	input wire logic [8:0]  o_detect_threshold,
	input wire logic [3:0]  o_call_strength
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	chk_level_range: assert property (o_sensitivity_level >= 4'h1 && o_sensitivity_level <= 4'h9)
		else $error("level out of range");
	chk_reset_level: assert property ($rose(i_rst_b) |-> o_sensitivity_level == 4'h6)
		else $error("level not 6 after reset");
	chk_thr_map: assert property (o_detect_threshold == (9'h001 << (4'h9 - o_sensitivity_level)))
		else $error("threshold does not match level");
	chk_idle_zero: assert property (!i_vehicle_detect[i_channel_select] |=> o_call_strength == 4'h0)
		else $error("strength not zero without vehicle");
	chk_call_seen: assert property (i_vehicle_detect[i_channel_select] && i_inductance_delta >= o_detect_threshold
		##1 $stable(o_sensitivity_level) |-> o_call_strength != 4'h0)
		else $error("strength zero above threshold");
	chk_det_follow: assert property (##1 o_vehicle_detect_indicator == $past(i_vehicle_detect))
		else $error("indicator does not follow detect");
	chk_step_one: assert property ($stable(i_channel_select) ##1 $changed(o_sensitivity_level)
		|-> (o_sensitivity_level - $past(o_sensitivity_level)) inside {4'h1, 4'hf})
		else $error("level stepped by more than one");
	chk_frequency_select_button_step: assert property ($stable(i_channel_select) ##1 $changed(o_frequency_level)
		|-> o_frequency_level == $past(o_frequency_level) + 2'h1)
		else $error("frequency level skipped");
endmodule

bind loop_panel loop_panel_props u_props
(
	.i_clk                      (i_clk),
	.i_rst_b                    (i_rst_b),
	.i_channel_select           (i_channel_select),
	.i_vehicle_detect           (i_vehicle_detect),
	.i_inductance_delta         (i_inductance_delta),
	.o_vehicle_detect_indicator (o_vehicle_detect_indicator),
	.o_sensitivity_level        (o_sensitivity_level),
	.o_frequency_level          (o_frequency_level),
	.o_detect_threshold         (o_detect_threshold),
	.o_call_strength            (o_call_strength)
);

// ===== verif/panel_front.sv
// Front panel push buttons as a user presses them.
// Assumes the panel samples its pins on the rising clock edge.
`timescale 1ns/1ps
module panel_front
(
	// Clock
	input wire logic  i_clk,
	// Pins: up, down, frequency, mode
	output logic [3:0] o_buttons
);
	// ****************
	// Presses
	// ****************
	initial o_buttons = 4'h0;
	// Low time of 3 cycles keeps two presses apart for the synchroniser
	task automatic press(input int b);
		@(posedge i_clk);
		#2 o_buttons[b] = 1'b1;
		repeat (3) @(posedge i_clk);
		#2 o_buttons[b] = 1'b0;
		repeat (3) @(posedge i_clk);
		// Return off the edge so callers never sample outputs as they launch
		#2;
	endtask
endmodule

// ===== verif/test_loop_panel.sv
// Self-checking bench for the loop panel control.
// Assumes short show times: 20 cycles per level display, 8 per character.
`timescale 1ns/1ps
module test_loop_panel;
	logic        i_clk;
	logic        i_rst_b;
	logic [1:0]  ch;
	logic [3:0]  vehicle_detect_indicator;
	logic [15:0] delta;
	logic [7:0]  frequency_select_button;
	logic [3:0]  btn;
	logic [6:0]  seg;
	logic [3:0]  ind;
	logic [3:0]  lvl;
	logic [1:0]  flvl;
	logic [1:0]  mode;
	logic [8:0]  thr;
	logic [3:0]  strength;
	int          fails;
	int          n_tests;
	int          cyc;
	// ****************
	// Instances and clock
	// ****************
	loop_panel #(.SENSITIVITY_STEP_BUTTONS_SHOW_CYCLES(20), .CHAR_SHOW_CYCLES(8)) DUT
	(
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sensitivity_step_buttons(btn[1:0]),
		.i_frequency_select_button(btn[2]), .i_mode_button(btn[3]), .i_channel_select(ch),
		.i_vehicle_detect(vehicle_detect_indicator), .i_inductance_delta(delta), .i_loop_frequency_select_button_khz(frequency_select_button),
		.o_segments(seg), .o_vehicle_detect_indicator(ind), .o_sensitivity_level(lvl),
		.o_frequency_level(flvl), .o_channel_mode(mode), .o_detect_threshold(thr),
		.o_call_strength(strength)
	);
	panel_front u_front (.i_clk(i_clk), .o_buttons(btn));
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// Hang guard: the run needs well under 1000 cycles
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			give_verdict();
		end
	end
	// ****************
	// Helpers
	// ****************
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		check("level", lvl, 9'h006);
		check("threshold", thr, 9'h008);
		check("segments", seg, 9'h03f);
		check("frequency_select_button level", flvl, 9'h000);
	endtask
	task automatic t_sensitivity_step_buttons();
		u_front.press(0);
		check("level", lvl, 9'h006);
		check("segments", seg, 9'h07d);
		u_front.press(0);
		check("level", lvl, 9'h007);
		check("segments", seg, 9'h007);
		u_front.press(1);
		u_front.press(1);
		check("level", lvl, 9'h005);
		step(25);
		check("segments", seg, 9'h03f);
	endtask
	task automatic t_saturate();
		repeat (6) u_front.press(0);
		check("level", lvl, 9'h009);
		check("threshold", thr, 9'h001);
		repeat (9) u_front.press(1);
		check("level", lvl, 9'h001);
		check("threshold", thr, 9'h100);
		step(25);
	endtask
	task automatic t_detect();
		vehicle_detect_indicator = 4'h1;
		delta = 16'h0400;
		step(2);
		check("indicator", ind, 9'h001);
		check("strength", strength, 9'h003);
		check("segments", seg, 9'h04f);
		u_front.press(0);
		check("level", lvl, 9'h002);
		check("strength", strength, 9'h004);
		check("segments", seg, 9'h066);
		vehicle_detect_indicator = 4'h0;
		step(2);
		check("indicator", ind, 9'h000);
		check("strength", strength, 9'h000);
		ch = 2'h1;
		step(2);
		check("other channel", lvl, 9'h006);
		ch = 2'h0;
		u_front.press(3);
		check("mode", mode, 9'h001);
	endtask
	task automatic t_frequency_select_button();
		logic [6:0] exp_seq [6];
		exp_seq = '{7'h06, 7'h40, 7'h5b, 7'h07, 7'h40, 7'h3f};
		u_front.press(2);
		step(3);
		foreach (exp_seq[i])
		begin
			check("frequency_select_button char", seg, exp_seq[i]);
			step(8);
		end
		u_front.press(2);
		u_front.press(2);
		check("frequency_select_button level", flvl, 9'h001);
		check("level char", seg, 9'h05b);
	endtask
	// Three digit frequency, so the hundreds digit is shown too
	task automatic t_frequency_select_button_wide();
		logic [6:0] exp_seq [6];
		exp_seq = '{7'h5b, 7'h40, 7'h06, 7'h6d, 7'h3f, 7'h40};
		frequency_select_button = 8'h96;
		step(50);
		u_front.press(2);
		step(3);
		foreach (exp_seq[i])
		begin
			check("wide char", seg, exp_seq[i]);
			step(8);
		end
		check("wide end", seg, 9'h03f);
	endtask
	// Reset in mid run brings every setting back to its default
	task automatic t_mid_reset();
		i_rst_b = 1'b0;
		step(2);
		i_rst_b = 1'b1;
		step(2);
		t_reset();
	endtask
	// ****************
	// Main sequence
	// ****************
	initial
	begin
		i_rst_b = 1'b0;
		ch = 2'h0;
		vehicle_detect_indicator = 4'h0;
		delta = 16'h0000;
		frequency_select_button = 8'h1b;
		repeat (20) @(posedge i_clk);
		#2 i_rst_b = 1'b1;
		step(2);
		t_reset();
		t_sensitivity_step_buttons();
		t_saturate();
		t_detect();
		t_frequency_select_button();
		t_frequency_select_button_wide();
		t_mid_reset();
		give_verdict();
	end
endmodule
